//--- drv_pkg.sv
// Types shared by the drive attention block.
// Assumes drv_regs.svh holds all numeric constants.
package drv_pkg;
  typedef logic [4:0] drv_func_t;
  typedef logic [15:0] drv_err_t;
  typedef enum logic [1:0] {
    DRV_OP_IDLE,
    DRV_OP_RUN,
    DRV_OP_REWIND
  } drv_op_state_e;
endpackage

//--- drv_regs.svh
// Offsets, fields, reset values and timing counts of the drive attention block.
// Assumes a 50 MHz pclk and word-aligned APB byte addresses.
`ifndef DRV_REGS_SVH
`define DRV_REGS_SVH
`define DRV_CLK_NS 20
`define DRV_PULSE_NS 200
`define DRV_REPLY_NS 70
`define DRV_PULSE_CYC ((`DRV_PULSE_NS + `DRV_CLK_NS - 1) / `DRV_CLK_NS)
`define DRV_REPLY_CYC ((`DRV_REPLY_NS + `DRV_CLK_NS - 1) / `DRV_CLK_NS)
`define DRV_OFS_CTRL 5'h00
`define DRV_OFS_STAT 5'h04
`define DRV_OFS_ERR 5'h08
`define DRV_OFS_MAINT 5'h0C
`define DRV_OFS_SERVICE_REQUEST_LINE 5'h10
`define DRV_OFS_TCTRL 5'h14
`define DRV_SEL_LSB 8
`define DRV_CTRL_RUN 0
`define DRV_TCTRL_ABORT_EN 12
`define DRV_ERR_BADFN 0
`define DRV_ERR_BADREG 1
`define DRV_ERR_REFUSED 2
`define DRV_ERR_DATA_BUS_PARITY_FAULT 5
`define DRV_ERR_DESKEW 6
`define DRV_ERR_FRAME 7
`define DRV_ERR_FIXUP 8
`define DRV_ERR_TIMING 12
`define DRV_ERR_UNFIN 13
`define DRV_ERR_UNSAFE 14
`define DRV_CLASS_B_MASK 16'h7001
`define DRV_DATA_ERR_MASK 16'h01E0
`define DRV_FN_NOP 5'h00
`define DRV_FN_REWIND 5'h03
`define DRV_FN_ERASE 5'h0A
`define DRV_FN_WTM 5'h0B
`define DRV_FN_SPACE_F 5'h0C
`define DRV_FN_SPACE_R 5'h0D
`define DRV_FN_WCHK 5'h14
`define DRV_FN_WRITE 5'h18
`define DRV_FN_READ_F 5'h1C
`define DRV_FN_READ_R 5'h1F
`define DRV_RST_TCTRL 16'h0000
`endif

//--- drv_service_request_line.sv
// Drive attention, error check and transfer-fault signalling with an APB register port.
// Assumes tape-side inputs share pclk; unit jumpers are asynchronous pins.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "drv_regs.svh"

// Notes on behaviour
// - Attention summary register answers whatever drive number the access carries.
// - On summary read, the service flag goes on the data bit equal to unit.
// - Flag clear means no data bit driven; unit offset by eight selects nothing.
// - Summary write: one on the unit's data bit clears the flag, zero keeps.
// - Loading control with run set triggers an error check; faults suppress the function.
// - Any error register bit set raises the fault summary.
// - Control load during fault: prior fault pulse, no busy, run cleared, flag set.
// - Erase, space or tape mark completion sets flag and raises service request.
// - Rewind start sets flag and raises service request at once.
// - Termination after a fault or slave change raises service request.
// - Termination after tape end marker raises service request.
// - Any fault during a busy transfer raises the block fault line.
// - Data-invalidating read fault aborts the transfer, tape read runs on.
// - Data-invalidating write fault aborts and ends the write via write finish.
// - Transfer attempted while a fault exists raises abort.
// - Fault arising during transfer initiation raises abort.
// - Class B or bad function fault during a transfer command raises abort.
// - Data errors during transfer abort only when the enable bit is set.
// - Writes refused while a non-rewind operation runs, except maintenance and summary.
// - Reply follows access pulse plus fixed delay; drops when strobe goes.
module drv_service_request_line
  import drv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] unit_number_jumpers,
  input wire logic [15:0] fault_set,
  input wire logic slave_change_flag,
  input wire logic tape_end_marker,
  input wire logic op_done,
  output logic op_start,
  output drv_func_t op_func,
  output logic busy_claim_line,
  output logic service_request_line,
  output logic block_fault_line,
  output logic abort_transfer_line,
  output logic write_finish,
  output logic prior_fault_pulse
);

  localparam logic [4:0] PULSE_CYC = 5'(`DRV_PULSE_CYC);
  localparam logic [4:0] REPLY_CYC = 5'(`DRV_REPLY_CYC);
  localparam logic [4:0] ANSWER_CYC = 5'(PULSE_CYC + REPLY_CYC);

  // Unit jumpers are pins
  logic [2:0] unit_meta_reg;
  logic [2:0] unit_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_meta_reg <= 3'h0;
      unit_reg <= 3'h0;
    end else begin
      unit_meta_reg <= unit_number_jumpers;
      unit_reg <= unit_meta_reg;
    end
  end

  // Register state
  logic run_reg, dns_reg, slave_seen_reg, fault_seen_reg, end_seen_reg;
  drv_func_t func_reg;
  drv_err_t err_reg, err_next;
  logic [15:0] maint_reg, tctrl_reg;
  drv_op_state_e op_state_reg;
  logic [4:0] wait_cnt_reg;

  // Address decode
  logic [4:0] ofs;
  logic [2:0] drive_sel;
  logic sel_ctrl, sel_stat, sel_err, sel_maint, sel_service_request_line, sel_tctrl, mapped, unit_hit, responds;

  assign ofs = paddr[4:0];
  assign drive_sel = paddr[`DRV_SEL_LSB+2:`DRV_SEL_LSB];
  assign sel_ctrl = (ofs == `DRV_OFS_CTRL);
  assign sel_stat = (ofs == `DRV_OFS_STAT);
  assign sel_err = (ofs == `DRV_OFS_ERR);
  assign sel_maint = (ofs == `DRV_OFS_MAINT);
  assign sel_service_request_line = (ofs == `DRV_OFS_SERVICE_REQUEST_LINE);
  assign sel_tctrl = (ofs == `DRV_OFS_TCTRL);
  assign mapped = sel_ctrl | sel_stat | sel_err | sel_maint | sel_service_request_line | sel_tctrl;
  assign unit_hit = (drive_sel == unit_reg) && (paddr[31:`DRV_SEL_LSB+3] == '0);
  assign responds = sel_service_request_line | unit_hit;

  // Handshake: access pulse then reply delay
  logic strobe, reply, xfer;
  assign strobe = psel & penable;
  assign reply = strobe & (wait_cnt_reg == ANSWER_CYC);
  assign pready = reply;
  assign xfer = strobe & reply;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_reg <= 5'h00;
    end else if (!strobe) begin
      wait_cnt_reg <= 5'h00;
    end else if (wait_cnt_reg != ANSWER_CYC) begin
      wait_cnt_reg <= wait_cnt_reg + 5'h01;
    end
  end

  // Write qualification
  logic wr, rd, op_running, refused, wr_ok, lo_strb;
  assign wr = xfer & pwrite & mapped & responds;
  assign rd = xfer & ~pwrite;
  assign op_running = (op_state_reg == DRV_OP_RUN);
  assign refused = wr & op_running & ~sel_maint & ~sel_service_request_line;
  assign wr_ok = wr & ~refused;
  assign lo_strb = pstrb[0];

  // Control load and error check
  logic ctrl_load, go_load, any_fault_summary, fn_xfer, fn_write, fn_rewind, fn_notify, fn_legal, bad_fn, start_ok;
  drv_func_t new_func;
  assign any_fault_summary = |err_reg;
  assign ctrl_load = wr_ok & sel_ctrl & lo_strb;
  assign go_load = ctrl_load & pwdata[`DRV_CTRL_RUN];
  assign new_func = pwdata[5:1];

  always_comb begin
    fn_xfer = 1'b0;
    fn_write = 1'b0;
    fn_rewind = 1'b0;
    fn_notify = 1'b0;
    fn_legal = 1'b1;
    unique case (new_func)
      `DRV_FN_NOP: fn_legal = 1'b1;
      `DRV_FN_REWIND: fn_rewind = 1'b1;
      `DRV_FN_ERASE, `DRV_FN_WTM, `DRV_FN_SPACE_F, `DRV_FN_SPACE_R: fn_notify = 1'b1;
      `DRV_FN_WRITE: begin
        fn_xfer = 1'b1;
        fn_write = 1'b1;
      end
      `DRV_FN_WCHK, `DRV_FN_READ_F, `DRV_FN_READ_R: fn_xfer = 1'b1;
      default: fn_legal = 1'b0;
    endcase
  end

  assign bad_fn = go_load & ~fn_legal;
  assign prior_fault_pulse = go_load & any_fault_summary;
  assign start_ok = go_load & fn_legal & ~any_fault_summary;

  // Operation bookkeeping
  logic xfer_op_reg, write_op_reg, notify_op_reg, op_end;
  assign op_end = op_running & op_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_state_reg <= DRV_OP_IDLE;
    end else if (start_ok & fn_rewind) begin
      op_state_reg <= DRV_OP_REWIND;
    end else if (start_ok & (new_func != `DRV_FN_NOP)) begin
      op_state_reg <= DRV_OP_RUN;
    end else if (op_done) begin
      op_state_reg <= DRV_OP_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_op_reg <= 1'b0;
      write_op_reg <= 1'b0;
      notify_op_reg <= 1'b0;
    end else if (start_ok) begin
      xfer_op_reg <= fn_xfer;
      write_op_reg <= fn_write;
      notify_op_reg <= fn_notify;
    end else if (op_end) begin
      xfer_op_reg <= 1'b0;
      write_op_reg <= 1'b0;
      notify_op_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      func_reg <= `DRV_FN_NOP;
    end else if (ctrl_load) begin
      run_reg <= start_ok & (new_func != `DRV_FN_NOP) & ~fn_rewind;
      func_reg <= new_func;
    end else if (op_end) begin
      run_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_start <= 1'b0;
      op_func <= `DRV_FN_NOP;
    end else begin
      op_start <= start_ok;
      if (start_ok) begin
        op_func <= new_func;
      end
    end
  end

  // Events seen during an operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_seen_reg <= 1'b0;
      fault_seen_reg <= 1'b0;
      end_seen_reg <= 1'b0;
    end else if (start_ok | op_end) begin
      slave_seen_reg <= 1'b0;
      fault_seen_reg <= 1'b0;
      end_seen_reg <= 1'b0;
    end else if (op_running) begin
      slave_seen_reg <= slave_seen_reg | slave_change_flag;
      fault_seen_reg <= fault_seen_reg | (|fault_set);
      end_seen_reg <= end_seen_reg | tape_end_marker;
    end
  end

  // Drive needs service flag
  logic dns_set, end_notify, dns_clr;
  assign end_notify = op_end & (notify_op_reg | slave_seen_reg | fault_seen_reg
                      | end_seen_reg | slave_change_flag | (|fault_set) | tape_end_marker);
  assign dns_set = prior_fault_pulse | (start_ok & fn_rewind) | end_notify;
  assign dns_clr = wr & sel_service_request_line & lo_strb & pwdata[unit_reg];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dns_reg <= 1'b0;
    end else if (dns_set) begin
      dns_reg <= 1'b1;
    end else if (dns_clr) begin
      dns_reg <= 1'b0;
    end
  end

  assign service_request_line = dns_reg;

  // Error register: hardware set wins over write-one clear
  drv_err_t hw_set;
  always_comb begin
    hw_set = fault_set;
    hw_set[`DRV_ERR_REFUSED] = fault_set[`DRV_ERR_REFUSED] | refused;
    hw_set[`DRV_ERR_BADREG] = fault_set[`DRV_ERR_BADREG] | (xfer & ~mapped & responds);
    hw_set[`DRV_ERR_BADFN] = fault_set[`DRV_ERR_BADFN] | bad_fn;
    err_next = err_reg;
    if (wr_ok & sel_err) begin
      err_next = err_reg & ~pwdata[15:0];
    end
    err_next = err_next | hw_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= '0;
    end else begin
      err_reg <= err_next;
    end
  end

  // Transfer claim and fault lines
  logic abort_cause, start_xfer_attempt;
  assign start_xfer_attempt = go_load & fn_xfer;
  assign abort_cause =
      (start_xfer_attempt & any_fault_summary)
    | (start_xfer_attempt & (|fault_set))
    | (busy_claim_line & (|(fault_set & `DRV_CLASS_B_MASK)))
    | (busy_claim_line & tctrl_reg[`DRV_TCTRL_ABORT_EN]
       & (|(fault_set & `DRV_DATA_ERR_MASK)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_claim_line <= 1'b0;
    end else if (start_ok & fn_xfer) begin
      busy_claim_line <= 1'b1;
    end else if (op_end | abort_cause) begin
      busy_claim_line <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_fault_line <= 1'b0;
    end else if (go_load) begin
      block_fault_line <= 1'b0;
    end else if (busy_claim_line & (|fault_set)) begin
      block_fault_line <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_transfer_line <= 1'b0;
    end else if (abort_cause) begin
      abort_transfer_line <= 1'b1;
    end else if (go_load) begin
      abort_transfer_line <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_finish <= 1'b0;
    end else begin
      write_finish <= abort_cause & write_op_reg & xfer_op_reg & op_running;
    end
  end

  // Maintenance and tape control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maint_reg <= 16'h0000;
    end else if (wr_ok & sel_maint & lo_strb) begin
      maint_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctrl_reg <= `DRV_RST_TCTRL;
    end else if (wr_ok & sel_tctrl & lo_strb) begin
      tctrl_reg <= pwdata[15:0];
    end
  end

  // Summary read: code {~flag, unit}; codes of eight and up select no bit
  logic [3:0] service_request_line_code;
  logic [31:0] service_request_line_word;
  assign service_request_line_code = {~dns_reg, unit_reg};

  always_comb begin
    service_request_line_word = 32'h0000_0000;
    if (service_request_line_code < 4'h8) begin
      service_request_line_word[service_request_line_code[2:0]] = 1'b1;
    end
  end

  // Read data mux
  logic [31:0] rd_mux;
  logic [15:0] stat_word;
  always_comb begin
    stat_word = 16'h0000;
    stat_word[0] = any_fault_summary;
    stat_word[1] = slave_change_flag;
    stat_word[2] = dns_reg;
    stat_word[3] = busy_claim_line;
    stat_word[4] = op_running;
    stat_word[5] = (op_state_reg == DRV_OP_REWIND);
    stat_word[6] = tape_end_marker;
    rd_mux = 32'h0000_0000;
    if (responds) begin
      unique case (1'b1)
        sel_ctrl: rd_mux = {26'h0, func_reg, run_reg};
        sel_stat: rd_mux = {16'h0, stat_word};
        sel_err: rd_mux = {16'h0, err_reg};
        sel_maint: rd_mux = {16'h0, maint_reg};
        sel_service_request_line: rd_mux = service_request_line_word;
        sel_tctrl: rd_mux = {16'h0, tctrl_reg};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (strobe & ~pwrite & (wait_cnt_reg == ANSWER_CYC - 5'h01)) begin
      prdata <= rd_mux;
    end else if (rd) begin
      prdata <= 32'h0000_0000;
    end
  end

  // Unmapped or other drive: error answer
  assign pslverr = reply & (~mapped | ~responds);

endmodule

//--- drv_service_request_line_checker.sv
// Concurrent checks on the ports of the drive attention block.
// Assumes it is bound to drv_service_request_line and sees only its ports.
`timescale 1ns/1ps
module drv_service_request_line_checker
  import drv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [2:0] unit_number_jumpers,
  input wire logic [15:0] fault_set,
  input wire logic op_start,
  input wire drv_func_t op_func,
  input wire logic busy_claim_line,
  input wire logic service_request_line,
  input wire logic block_fault_line,
  input wire logic abort_transfer_line,
  input wire logic prior_fault_pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  reply_time_a: assert property (pready |-> penable && $past(penable, 14) && !$past(penable, 15))
    else $error("reply at wrong time");
  reply_single_a: assert property (pready |=> !pready)
    else $error("reply held too long");
  summary_read_a: assert property (pready && !pwrite && paddr[4:0] == 5'h10 |->
    prdata == (32'($past(service_request_line)) << unit_number_jumpers)) else $error("summary read data wrong");
  flag_clear_a: assert property ($fell(service_request_line) |->
    $past(pready && pwrite && paddr[4:0] == 5'h10 && pwdata[unit_number_jumpers])) else $error("flag lost");
  prior_fault_a: assert property (prior_fault_pulse |=> service_request_line && !busy_claim_line && !op_start)
    else $error("prior fault handling wrong");
  start_cause_a: assert property (op_start |->
    $past(pready && pwrite && paddr[4:0] == 5'h00 && pwdata[0] && !prior_fault_pulse)) else $error("stray start");
  rewind_flag_a: assert property (op_start && op_func == 5'h03 |-> service_request_line)
    else $error("rewind without flag");
  busy_fault_a: assert property (busy_claim_line && |fault_set |=> block_fault_line)
    else $error("block fault missing");
  class_abort_a: assert property (busy_claim_line && |(fault_set & 16'h7001) |=> abort_transfer_line)
    else $error("class b abort missing");
  abort_cause_a: assert property ($rose(abort_transfer_line) |-> $past(|fault_set || (pready && pwrite)))
    else $error("abort without cause");
endmodule
bind drv_service_request_line drv_service_request_line_checker u_drv_service_request_line_checker (.pclk, .presetn, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .unit_number_jumpers, .fault_set, .op_start, .op_func, .busy_claim_line, .service_request_line,
  .block_fault_line, .abort_transfer_line, .prior_fault_pulse);

//--- drv_service_request_line_tb.sv
// Directed testbench for the drive attention block over APB.
// Assumes the tape model ends each operation 40 cycles after its start.
`timescale 1ns/1ps
`include "drv_regs.svh"
module drv_service_request_line_tb
  import drv_pkg::*;
;
  localparam logic [4:0] ctl = `DRV_OFS_CTRL;
  localparam logic [4:0] err = `DRV_OFS_ERR;
  localparam logic [4:0] sta = `DRV_OFS_STAT;
  localparam logic [4:0] att = `DRV_OFS_SERVICE_REQUEST_LINE;
  localparam logic [4:0] tct = `DRV_OFS_TCTRL;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] fault_set = 16'h0;
  logic end_mark = 1'b0;
  logic slave_change_flag = 1'b0;
  logic [2:0] unit_pins = 3'h5;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, op_done, op_start, tape_end_marker, busy_claim_line, service_request_line;
  logic block_fault_line, abort_transfer_line, write_finish, prior_fault_pulse;
  drv_func_t op_func;
  int bad_count = 0;
  int n_tests = 0;
  int pf_n = 0;
  int wf_n = 0;
  int os_n = 0;
  always #10 pclk = ~pclk;
  drv_service_request_line u_drv_service_request_line (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
    .pslverr, .unit_number_jumpers(unit_pins), .fault_set, .slave_change_flag, .tape_end_marker, .op_done,
    .op_start, .op_func, .busy_claim_line, .service_request_line, .block_fault_line, .abort_transfer_line,
    .write_finish, .prior_fault_pulse);
  drv_tape_model u_drv_tape_model (.pclk, .presetn, .op_start, .done_delay(8'h28), .end_mark, .op_done,
    .tape_end_marker);
  always @(negedge pclk) begin
    pf_n += int'(prior_fault_pulse === 1'b1);
    wf_n += int'(write_finish === 1'b1);
    os_n += int'(op_start === 1'b1);
  end
  function automatic logic [31:0] cmd(input drv_func_t f);
    return {26'h0, f, 1'b1};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic xfer(input logic w, input logic [4:0] ofs, input logic [2:0] drv, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {21'h0, drv, 3'h0, ofs};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until the edge that samples pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] ofs, input logic [31:0] d);
    xfer(1'b1, ofs, 3'h5, d);
  endtask
  task automatic rc(input string nm, input logic [4:0] ofs, input logic [2:0] drv, input logic [31:0] exp);
    xfer(1'b0, ofs, drv, 32'h0);
    chk(nm, exp, rdat);
  endtask
  task automatic pulse(input logic [15:0] f);
    @(posedge pclk);
    fault_set <= f;
    @(posedge pclk);
    fault_set <= 16'h0;
    @(negedge pclk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (op_done !== 1'b1 && n < 500);
    chk("op end", 32'h1, 32'(op_done));
  endtask
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rc("summary idle", att, 3'h2, 32'h0);
    wr(ctl, cmd(`DRV_FN_ERASE));
    wait_done();
    rc("summary erase", att, 3'h7, 32'h20);
    chk("attention line", 32'h1, 32'(service_request_line));
    wr(att, 32'hFFFFFFDF);
    rc("summary kept", att, 3'h0, 32'h20);
    wr(att, 32'h20);
    rc("summary cleared", att, 3'h5, 32'h0);
    wr(ctl, cmd(`DRV_FN_REWIND));
    rc("summary rewind", att, 3'h5, 32'h20);
    wait_done();
    wr(att, 32'h20);
    end_mark <= 1'b1;
    wr(ctl, cmd(`DRV_FN_READ_F));
    @(negedge pclk);
    chk("busy", 32'h1, 32'(busy_claim_line));
    pulse(16'h0040);
    chk("block fault", 32'h1, 32'(block_fault_line));
    chk("data abort off", 32'h0, 32'(abort_transfer_line));
    wr(tct, 32'h1000);
    pulse(16'h4000);
    chk("class b abort", 32'h1, 32'(abort_transfer_line));
    wait_done();
    end_mark <= 1'b0;
    rc("status", sta, 3'h5, 32'h5);
    rc("error bits", err, 3'h5, 32'h4044);
    rc("summary end", att, 3'h5, 32'h20);
    rc("tape control kept", tct, 3'h5, 32'h0);
    wr(err, 32'hFFFF);
    wr(att, 32'h20);
    rc("error clear", err, 3'h5, 32'h0);
    wr(ctl, cmd(`DRV_FN_READ_R));
    slave_change_flag <= 1'b1;
    @(posedge pclk);
    slave_change_flag <= 1'b0;
    wait_done();
    rc("summary slave", att, 3'h5, 32'h20);
    chk("abort cleared", 32'h0, 32'(abort_transfer_line));
    chk("block cleared", 32'h0, 32'(block_fault_line));
    wr(att, 32'h20);
    wr(tct, 32'h1000);
    wr(ctl, cmd(`DRV_FN_WRITE));
    pulse(16'h0020);
    chk("write abort", 32'h1, 32'(abort_transfer_line));
    wait_done();
    chk("write finish", 32'h1, 32'(wf_n));
    wr(err, 32'hFFFF);
    wr(att, 32'h20);
    wr(ctl, cmd(`DRV_FN_NOP));
    @(negedge pclk);
    chk("abort before prior", 32'h0, 32'(abort_transfer_line));
    pulse(16'h0020);
    chk("no abort when idle", 32'h0, 32'(abort_transfer_line));
    wr(ctl, cmd(`DRV_FN_READ_F));
    @(negedge pclk);
    chk("prior pulse", 32'h1, 32'(pf_n));
    chk("no busy", 32'h0, 32'(busy_claim_line));
    chk("start count", 32'h6, 32'(os_n));
    chk("prior abort", 32'h1, 32'(abort_transfer_line));
    rc("summary prior", att, 3'h5, 32'h20);
    xfer(1'b0, 5'h1C, 3'h5, 32'h0);
    chk("unmapped", 32'h1, 32'(rerr));
    xfer(1'b0, ctl, 3'h2, 32'h0);
    chk("other drive", 32'h1, 32'(rerr));
    rc("error final", err, 3'h5, 32'h0022);
    unit_pins <= 3'h2;
    repeat (3) @(posedge pclk);
    rc("summary unit two", att, 3'h0, 32'h4);
    complete_run();
  end
  initial begin
    repeat (4000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
endmodule

//--- drv_tape_model.sv
// Tape-side model: ends each started operation after a set delay.
// Assumes op_start is a one-cycle pulse on pclk.
`timescale 1ns/1ps
module drv_tape_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic op_start,
  input wire logic [7:0] done_delay,
  input wire logic end_mark,
  output logic op_done,
  output logic tape_end_marker
);
  logic [7:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
      op_done <= 1'b0;
      tape_end_marker <= 1'b0;
    end else begin
      op_done <= cnt_reg == 8'h01;
      tape_end_marker <= end_mark && cnt_reg != 8'h00;
      if (op_start) begin
        cnt_reg <= done_delay;
      end else if (cnt_reg != 8'h00) begin
        // Motion runs on after an abort
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule
